// ### rtl/program_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module program_status_flags (
	input  wire logic                             clk,
	input  wire logic                             arst_n,
	input  wire logic                             ce,
	input  wire logic [7:0]                       sfrAddr,
	input  wire logic                             sfrWrEn,
	input  wire logic [psw_pkg::DATA_W-1:0]       sfrWrData,
	input  wire logic                             sfrRdEn,
	output logic      [psw_pkg::DATA_W-1:0]       sfrRdData,
	output logic                                  sfrRdHit,
	input  wire logic [7:0]                       bitAddr,
	input  wire logic                             bitWrEn,
	input  wire logic                             bitWrData,
	input  wire logic                             bitRdEn,
	output logic                                  bitRdData,
	output logic                                  bitRdHit,
	input  wire logic                             aluUpdate,
	input  wire psw_pkg::arith_op_t               aluOp,
	input  wire logic [psw_pkg::DATA_W-1:0]       aluOperandA,
	input  wire logic [psw_pkg::DATA_W-1:0]       aluOperandB,
	input  wire logic [psw_pkg::DATA_W-1:0]       accValue,
	input  wire logic [psw_pkg::REG_IDX_W-1:0]    regIndex,
	output logic      [psw_pkg::RAM_ADDR_W-1:0]   bankRamAddr,
	output logic      [psw_pkg::DATA_W-1:0]       pswValue
);

	// Field registers of the status word.
	// Bit zero has no software-written storage; only the parity copy lives here.
	logic                           carry_r;
	logic                           halfCarry_r;
	logic                           userFlag0_r;
	logic [psw_pkg::BANK_W-1:0]     bank_r;
	logic                           overflow_r;
	logic                           userFlag1_r;
	logic                           parity_r;

	// Registered answers toward the core.
	logic [psw_pkg::DATA_W-1:0]     sfrRdData_r;
	logic                           sfrRdHit_r;
	logic                           bitRdData_r;
	logic                           bitRdHit_r;
	logic [psw_pkg::RAM_ADDR_W-1:0] bankRamAddr_r;

	// Decode results.
	// These are combinational views of the requests in the current cycle.
	logic                           byteSel;
	logic                           bitSel;
	logic [psw_pkg::BIT_SEL_W-1:0]  bitPos;
	logic                           byteWr;
	logic                           bitWr;
	logic [psw_pkg::DATA_W-1:0]     pswNow;
	logic                           parityNow;
	logic [psw_pkg::RAM_ADDR_W-1:0] bankAddrMapped;

	// Arithmetic flag computation.
	// Only the carry, half-carry and overflow fields depend on these terms.
	logic                           carryIn;
	logic [psw_pkg::DATA_W:0]       sumFull;
	logic [psw_pkg::NIBBLE_W:0]     sumLow;
	logic [psw_pkg::DATA_W:0]       diffFull;
	logic [psw_pkg::NIBBLE_W:0]     diffLow;
	logic [psw_pkg::PROD_W-1:0]     product;
	logic                           carry_nxt;
	logic                           halfCarry_nxt;
	logic                           overflow_nxt;
	logic                           aluTouchCarry;
	logic                           aluTouchOvfl;

	// Odd parity of the accumulator, evaluated continuously.
	// Reads take this live value, so software never sees a stale parity bit.
	parity_tree #(
		.WIDTH (psw_pkg::DATA_W)
	) accParity (
		.data  (accValue),
		.odd   (parityNow)
	);

	// Working register operand mapped onto the selected bank.
	// A bank change reaches the operand address one cycle after the write.
	bank_address_map bankMap (
		.bank     (bank_r),
		.regIndex (regIndex),
		.ramAddr  (bankAddrMapped)
	);

	// The byte answers at one address only; all eight address bits are compared.
	assign byteSel = (sfrAddr == psw_pkg::PSW_SFR_ADDR);

	// Bit addresses of this byte share its upper five address bits.
	assign bitSel = (bitAddr[7:psw_pkg::BIT_SEL_W] == psw_pkg::PSW_SFR_ADDR[7:psw_pkg::BIT_SEL_W]);
	assign bitPos = bitAddr[psw_pkg::BIT_SEL_W-1:0];

	// Write strobes for this word; a byte write masks a bit write in the same cycle,
	// so the two software paths never fight over one field.
	assign byteWr = sfrWrEn && byteSel;
	assign bitWr  = bitWrEn && bitSel && !byteWr;

	// Current contents as seen by a read, parity always fresh.
	// Starting from the reset word keeps every bit assigned on every path.
	always_comb begin
		pswNow = psw_pkg::PSW_RESET;
		pswNow[psw_pkg::CARRY_POS] = carry_r;
		pswNow[psw_pkg::HALF_POS] = halfCarry_r;
		pswNow[psw_pkg::UFLAG0_POS] = userFlag0_r;
		pswNow[psw_pkg::BANK_HI:psw_pkg::BANK_LO] = bank_r;
		pswNow[psw_pkg::OVFL_POS] = overflow_r;
		pswNow[psw_pkg::UFLAG1_POS] = userFlag1_r;
		pswNow[psw_pkg::PARITY_POS] = parityNow;
	end

	// Sums, differences and product for the flag results.
	// One extra bit on each sum holds the carry or borrow out of its top bit.
	// The stored carry feeds add-with-carry and subtract-with-borrow alike.
	always_comb begin
		carryIn  = ((aluOp == psw_pkg::ARITH_ADD_WITH_CARRY_INSTRUCTION) || (aluOp == psw_pkg::ARITH_SUBTRACT_WITH_BORROW_INSTRUCTION)) ? carry_r : 1'b0;
		sumFull  = {1'b0, aluOperandA} + {1'b0, aluOperandB} + {8'h00, carryIn};
		sumLow   = {1'b0, aluOperandA[psw_pkg::NIBBLE_W-1:0]}
			+ {1'b0, aluOperandB[psw_pkg::NIBBLE_W-1:0]} + {4'h0, carryIn};
		diffFull = {1'b0, aluOperandA} - {1'b0, aluOperandB} - {8'h00, carryIn};
		diffLow  = {1'b0, aluOperandA[psw_pkg::NIBBLE_W-1:0]}
			- {1'b0, aluOperandB[psw_pkg::NIBBLE_W-1:0]} - {4'h0, carryIn};
		product  = {8'h00, aluOperandA} * {8'h00, aluOperandB};
	end

	// Flag results per operation class.
	// Codes outside the named classes leave every flag alone, so a stray code
	// from the core cannot disturb the word.
	always_comb begin
		carry_nxt     = 1'b0;
		halfCarry_nxt = 1'b0;
		overflow_nxt  = 1'b0;
		aluTouchCarry = 1'b1;
		aluTouchOvfl  = 1'b1;
		case (aluOp)
			psw_pkg::ARITH_ADD,
			psw_pkg::ARITH_ADD_WITH_CARRY_INSTRUCTION: begin
				carry_nxt     = sumFull[psw_pkg::DATA_W];
				halfCarry_nxt = sumLow[psw_pkg::NIBBLE_W];
				overflow_nxt  = (aluOperandA[psw_pkg::SIGN_POS] == aluOperandB[psw_pkg::SIGN_POS])
					&& (sumFull[psw_pkg::SIGN_POS] != aluOperandA[psw_pkg::SIGN_POS]);
			end
			psw_pkg::ARITH_SUBTRACT_WITH_BORROW_INSTRUCTION: begin
				carry_nxt     = diffFull[psw_pkg::DATA_W];
				halfCarry_nxt = diffLow[psw_pkg::NIBBLE_W];
				overflow_nxt  = (aluOperandA[psw_pkg::SIGN_POS] != aluOperandB[psw_pkg::SIGN_POS])
					&& (diffFull[psw_pkg::SIGN_POS] != aluOperandA[psw_pkg::SIGN_POS]);
			end
			psw_pkg::ARITH_MUL: begin
				overflow_nxt = (product > psw_pkg::PRODUCT_MAX);
			end
			psw_pkg::ARITH_DIV: begin
				overflow_nxt = (aluOperandB == 8'h00);
			end
			psw_pkg::ARITH_OTHER: begin
				aluTouchOvfl = 1'b0; // Carry and half-carry cleared
			end
			default: begin
				aluTouchCarry = 1'b0;
				aluTouchOvfl  = 1'b0;
			end
		endcase
	end

	// Carry bit: arithmetic result wins over a same-cycle software write.
	// Giving the instruction priority keeps a hardware set from being lost
	// to a software clear that lands in the same cycle.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			carry_r <= psw_pkg::PSW_RESET[psw_pkg::CARRY_POS];
		end else if (ce) begin
			if (aluUpdate && aluTouchCarry) begin
				carry_r <= carry_nxt;
			end else if (byteWr) begin
				carry_r <= sfrWrData[psw_pkg::CARRY_POS];
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::CARRY_POS))) begin
				carry_r <= bitWrData;
			end
		end
	end

	// Half-carry bit, same precedence as the carry.
	// The instruction result replaces it whenever it replaces the carry.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			halfCarry_r <= psw_pkg::PSW_RESET[psw_pkg::HALF_POS];
		end else if (ce) begin
			if (aluUpdate && aluTouchCarry) begin
				halfCarry_r <= halfCarry_nxt;
			end else if (byteWr) begin
				halfCarry_r <= sfrWrData[psw_pkg::HALF_POS];
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::HALF_POS))) begin
				halfCarry_r <= bitWrData;
			end
		end
	end

	// Overflow bit, same precedence as the carry.
	// Operations outside the five flag-setting classes leave it untouched.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overflow_r <= psw_pkg::PSW_RESET[psw_pkg::OVFL_POS];
		end else if (ce) begin
			if (aluUpdate && aluTouchOvfl) begin
				overflow_r <= overflow_nxt;
			end else if (byteWr) begin
				overflow_r <= sfrWrData[psw_pkg::OVFL_POS];
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::OVFL_POS))) begin
				overflow_r <= bitWrData;
			end
		end
	end

	// User flags, never touched by instruction side effects.
	// A byte write sets both at once; a bit write sets one of them.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			userFlag0_r <= psw_pkg::PSW_RESET[psw_pkg::UFLAG0_POS];
			userFlag1_r <= psw_pkg::PSW_RESET[psw_pkg::UFLAG1_POS];
		end else if (ce) begin
			if (byteWr) begin
				userFlag0_r <= sfrWrData[psw_pkg::UFLAG0_POS];
				userFlag1_r <= sfrWrData[psw_pkg::UFLAG1_POS];
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::UFLAG0_POS))) begin
				userFlag0_r <= bitWrData;
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::UFLAG1_POS))) begin
				userFlag1_r <= bitWrData;
			end
		end
	end

	// Bank select field, written by byte or by either of its two bits.
	// A bit write changes one half of the field and keeps the other half.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bank_r <= psw_pkg::PSW_RESET[psw_pkg::BANK_HI:psw_pkg::BANK_LO];
		end else if (ce) begin
			if (byteWr) begin
				bank_r <= sfrWrData[psw_pkg::BANK_HI:psw_pkg::BANK_LO];
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::BANK_HI))) begin
				bank_r[1] <= bitWrData;
			end else if (bitWr && (bitPos == psw_pkg::BIT_SEL_W'(psw_pkg::BANK_LO))) begin
				bank_r[0] <= bitWrData;
			end
		end
	end

	// Parity copy refreshed each cycle; writes never reach it.
	// It feeds the status word output, which therefore trails the accumulator by one cycle.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			parity_r <= psw_pkg::PSW_RESET[psw_pkg::PARITY_POS];
		end else if (ce) begin
			parity_r <= parityNow;
		end
	end

	// Byte read answer, one cycle after the request; zero when not selected.
	// Returning zero when not selected lets the core combine all answers with an OR.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrRdData_r <= psw_pkg::PSW_RESET;
			sfrRdHit_r  <= 1'b0;
		end else if (ce) begin
			sfrRdHit_r  <= sfrRdEn && byteSel;
			sfrRdData_r <= (sfrRdEn && byteSel) ? pswNow : 8'h00;
		end
	end

	// Single bit read answer, one cycle after the request.
	// The parity bit reads its live value here as well.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bitRdData_r <= 1'b0;
			bitRdHit_r  <= 1'b0;
		end else if (ce) begin
			bitRdHit_r  <= bitRdEn && bitSel;
			bitRdData_r <= bitRdEn && bitSel && pswNow[bitPos];
		end
	end

	// Bank register address for the working register operand.
	// Registering the address gives the core a settled operand address each cycle.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bankRamAddr_r <= '0;
		end else if (ce) begin
			bankRamAddr_r <= bankAddrMapped;
		end
	end

	// Output drive from the registers.
	// Every output comes straight from a flip-flop.
	assign sfrRdData   = sfrRdData_r;
	assign sfrRdHit    = sfrRdHit_r;
	assign bitRdData   = bitRdData_r;
	assign bitRdHit    = bitRdHit_r;
	assign bankRamAddr = bankRamAddr_r;
	assign pswValue    = {carry_r, halfCarry_r, userFlag0_r, bank_r, overflow_r, userFlag1_r, parity_r};

endmodule // program_status_flags
`default_nettype wire

// ### common/psw_pkg.sv
`default_nettype none
package psw_pkg;

	// Data path and field widths.
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned NIBBLE_W   = 4;
	localparam int unsigned BANK_W     = 2;
	localparam int unsigned REG_IDX_W  = 3;
	localparam int unsigned BIT_SEL_W  = 3;
	localparam int unsigned RAM_ADDR_W = 8;
	localparam int unsigned PROD_W     = 16;

	// Location of the status word in special function space.
	localparam logic [7:0] PSW_SFR_ADDR = 8'hd0;
	localparam logic [7:0] PSW_RESET    = 8'h00;

	// Bit positions inside the status word.
	localparam int unsigned CARRY_POS  = 7;
	localparam int unsigned HALF_POS   = 6;
	localparam int unsigned UFLAG0_POS = 5;
	localparam int unsigned BANK_HI    = 4;
	localparam int unsigned BANK_LO    = 3;
	localparam int unsigned OVFL_POS   = 2;
	localparam int unsigned UFLAG1_POS = 1;
	localparam int unsigned PARITY_POS = 0;

	// Sign bit of an operand and the largest product that fits a byte.
	localparam int unsigned SIGN_POS    = 7;
	localparam logic [15:0] PRODUCT_MAX = 16'h00ff;

	// Arithmetic operation classes reported by the execution unit.
	typedef enum logic [2:0] {
		ARITH_ADD,
		ARITH_ADD_WITH_CARRY_INSTRUCTION,
		ARITH_SUBTRACT_WITH_BORROW_INSTRUCTION,
		ARITH_MUL,
		ARITH_DIV,
		ARITH_OTHER
	} arith_op_t;

endpackage
`default_nettype wire

// ### rtl/parity_tree.sv
`timescale 1ns/1ps
`default_nettype none
module parity_tree #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] data,
	output logic                  odd
);

	// One when the number of set bits is odd.
	assign odd = ^data;

endmodule // parity_tree
`default_nettype wire

// ### rtl/bank_address_map.sv
`timescale 1ns/1ps
`default_nettype none
module bank_address_map (
	input  wire logic [psw_pkg::BANK_W-1:0]     bank,
	input  wire logic [psw_pkg::REG_IDX_W-1:0]  regIndex,
	output logic      [psw_pkg::RAM_ADDR_W-1:0] ramAddr
);

	localparam int unsigned PAD_W = psw_pkg::RAM_ADDR_W - psw_pkg::BANK_W - psw_pkg::REG_IDX_W;

	// Bank n covers eight bytes starting at eight times n.
	assign ramAddr = {{PAD_W{1'b0}}, bank, regIndex};

endmodule // bank_address_map
`default_nettype wire

// ### sim/core_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_exec_model (
	input  wire logic               clk,
	output var  logic               aluUpdate,
	output var  psw_pkg::arith_op_t aluOp,
	output var  logic [7:0]         aluOperandA,
	output var  logic [7:0]         aluOperandB,
	output var  logic [7:0]         accValue
);
	// The core starts idle with an empty accumulator.
	initial begin
		aluUpdate = 1'b0;
		aluOp = psw_pkg::ARITH_OTHER;
		aluOperandA = 8'h00;
		aluOperandB = 8'h00;
		accValue = 8'h00;
	end

	// Completes one instruction after an optional stall, then scrambles the operand lines.
	task automatic exec(input psw_pkg::arith_op_t op, input logic [7:0] a, input logic [7:0] b, input int gap);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		aluUpdate = 1'b1;
		aluOp = op;
		aluOperandA = a;
		aluOperandB = b;
		@(negedge clk);
		aluUpdate = 1'b0;
		aluOp = psw_pkg::ARITH_OTHER;
		aluOperandA = ~a;
		aluOperandB = ~b;
	endtask

	// Loads a new accumulator value.
	task automatic setAcc(input logic [7:0] v);
		@(negedge clk);
		accValue = v;
	endtask
endmodule // core_exec_model
`default_nettype wire

// ### sim/program_status_flags_sva.sv
`timescale 1ns/1ps
`default_nettype none
module program_status_flags_sva (
	input wire logic               clk,
	input wire logic               arst_n,
	input wire logic               ce,
	input wire logic [7:0]         sfrAddr,
	input wire logic               sfrWrEn,
	input wire logic [7:0]         sfrWrData,
	input wire logic               sfrRdEn,
	input wire logic [7:0]         sfrRdData,
	input wire logic               sfrRdHit,
	input wire logic               bitWrEn,
	input wire logic               aluUpdate,
	input wire psw_pkg::arith_op_t aluOp,
	input wire logic [7:0]         aluOperandA,
	input wire logic [7:0]         aluOperandB,
	input wire logic [7:0]         accValue,
	input wire logic [2:0]         regIndex,
	input wire logic [7:0]         bankRamAddr,
	input wire logic [7:0]         pswValue
);
	// Reference carry, half-carry and overflow for add and subtract.
	logic        cin;
	logic [8:0]  addRes;
	logic [8:0]  subRes;
	logic [4:0]  addNib;
	logic [4:0]  subNib;
	logic [2:0]  arithExp;
	logic [15:0] prod;
	assign cin = pswValue[7] && (aluOp != psw_pkg::ARITH_ADD);
	assign addRes = {1'b0, aluOperandA} + {1'b0, aluOperandB} + {8'h00, cin};
	assign subRes = {1'b0, aluOperandA} - {1'b0, aluOperandB} - {8'h00, cin};
	assign addNib = {1'b0, aluOperandA[3:0]} + {1'b0, aluOperandB[3:0]} + {4'h0, cin};
	assign subNib = {1'b0, aluOperandA[3:0]} - {1'b0, aluOperandB[3:0]} - {4'h0, cin};
	assign arithExp = (aluOp == psw_pkg::ARITH_SUBTRACT_WITH_BORROW_INSTRUCTION)
		? {subRes[8], subNib[4], (aluOperandA[7] != aluOperandB[7]) && (subRes[7] != aluOperandA[7])}
		: {addRes[8], addNib[4], (aluOperandA[7] == aluOperandB[7]) && (addRes[7] != aluOperandA[7])};
	assign prod = {8'h00, aluOperandA} * {8'h00, aluOperandB};

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	read_hit_a: assert property (ce && sfrRdEn && sfrAddr == 8'hd0 |=> sfrRdHit
		&& sfrRdData[7:1] == $past(pswValue[7:1]) && sfrRdData[0] == ^$past(accValue)) else $error("bad read");
	read_miss_a: assert property (ce && !(sfrRdEn && sfrAddr == 8'hd0) |=> !sfrRdHit
		&& sfrRdData == 8'h00) else $error("stray read answer");
	byte_write_a: assert property (ce && sfrWrEn && sfrAddr == 8'hd0 && !aluUpdate |=>
		pswValue[7:1] == $past(sfrWrData[7:1])) else $error("byte write lost");
	parity_track_a: assert property (ce |=> pswValue[0] == ^$past(accValue)) else $error("parity wrong");
	user_flags_a: assert property (ce && !sfrWrEn && !bitWrEn |=> $stable(pswValue[5])
		&& $stable(pswValue[1]) && $stable(pswValue[4:3])) else $error("software field changed");
	bank_map_a: assert property (ce |=>
		bankRamAddr == {3'b000, $past(pswValue[4:3]), $past(regIndex)}) else $error("bank address wrong");
	add_sub_a: assert property (ce && aluUpdate && aluOp inside {psw_pkg::ARITH_ADD, psw_pkg::ARITH_ADD_WITH_CARRY_INSTRUCTION,
		psw_pkg::ARITH_SUBTRACT_WITH_BORROW_INSTRUCTION} |=> {pswValue[7:6], pswValue[2]} == $past(arithExp)) else $error("add flags wrong");
	mul_ovfl_a: assert property (ce && aluUpdate && aluOp == psw_pkg::ARITH_MUL |=> pswValue[7:6] == 2'b00
		&& pswValue[2] == ($past(prod) > 16'h00ff)) else $error("multiply flags wrong");
	div_ovfl_a: assert property (ce && aluUpdate && aluOp == psw_pkg::ARITH_DIV |=> pswValue[7:6] == 2'b00
		&& pswValue[2] == ($past(aluOperandB) == 8'h00)) else $error("divide flags wrong");
endmodule // program_status_flags_sva
`default_nettype wire

// ### sim/program_status_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
module program_status_flags_bench;
	logic               clk, arst_n, ce, sfrWrEn, sfrRdEn, sfrRdHit;
	logic               bitWrEn, bitWrData, bitRdEn, bitRdData, bitRdHit, aluUpdate;
	logic [7:0]         sfrAddr, sfrWrData, sfrRdData, bitAddr, aluOperandA, aluOperandB;
	logic [7:0]         accValue, bankRamAddr, pswValue;
	logic [2:0]         regIndex;
	psw_pkg::arith_op_t aluOp;
	int                 badCount, testsRun;
	// Operation, operands and expected carry, half-carry, overflow.
	logic [21:0]        tbl [10] = '{{3'h0, 8'h7f, 8'h01, 3'b011}, {3'h0, 8'hff, 8'h01, 3'b110},
		{3'h1, 8'h00, 8'h00, 3'b000}, {3'h2, 8'h00, 8'h01, 3'b110}, {3'h2, 8'h80, 8'h01, 3'b011},
		{3'h3, 8'h10, 8'h10, 3'b001}, {3'h3, 8'h0f, 8'h11, 3'b000}, {3'h4, 8'h05, 8'h01, 3'b000},
		{3'h4, 8'h05, 8'h00, 3'b001}, {3'h5, 8'h12, 8'h34, 3'b001}};

	program_status_flags dut (.clk, .arst_n, .ce, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
		.sfrRdHit, .bitAddr, .bitWrEn, .bitWrData, .bitRdEn, .bitRdData, .bitRdHit, .aluUpdate, .aluOp,
		.aluOperandA, .aluOperandB, .accValue, .regIndex, .bankRamAddr, .pswValue);
	core_exec_model core (.clk, .aluUpdate, .aluOp, .aluOperandA, .aluOperandB, .accValue);

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic giveVerdict();
		if (badCount == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One byte access; a read compares {hit, data} one cycle later.
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [8:0] exp);
		@(negedge clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = wr;
		sfrRdEn = !wr;
		@(negedge clk);
		sfrWrEn = 1'b0;
		sfrRdEn = 1'b0;
		if (!wr) check({7'h00, sfrRdHit, sfrRdData}, {7'h00, exp});
	endtask

	// One bit access; a read compares {hit, data} one cycle later.
	task automatic bitOp(input logic wr, input logic [7:0] a, input logic d, input logic [1:0] exp);
		@(negedge clk);
		bitAddr = a;
		bitWrData = d;
		bitWrEn = wr;
		bitRdEn = !wr;
		@(negedge clk);
		bitWrEn = 1'b0;
		bitRdEn = 1'b0;
		if (!wr) check({14'h0000, bitRdHit, bitRdData}, {14'h0000, exp});
	endtask

	// Main sequence: reset, byte and bit access, bank mapping, arithmetic flags.
	initial begin
		{badCount, testsRun} = '0;
		{arst_n, sfrWrEn, sfrRdEn, bitWrEn, bitWrData, bitRdEn} = '0;
		{sfrAddr, sfrWrData, bitAddr, regIndex} = '0;
		ce = 1'b1;
		repeat (16) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		check({8'h00, pswValue}, 16'h0000);
		core.setAcc(8'h03);
		sfr(1'b1, 8'hd0, 8'hff, 9'h000);
		sfr(1'b0, 8'hd0, 8'h00, 9'h1fe);
		core.setAcc(8'h07);
		sfr(1'b0, 8'hd0, 8'h00, 9'h1ff);
		sfr(1'b1, 8'hd1, 8'h00, 9'h000);
		sfr(1'b0, 8'hd1, 8'h00, 9'h000);
		bitOp(1'b1, 8'hd5, 1'b0, 2'b00);
		bitOp(1'b1, 8'hd1, 1'b0, 2'b00);
		bitOp(1'b1, 8'hd0, 1'b0, 2'b00);
		bitOp(0, 8'hd5, 1'b0, 2'b10);
		bitOp(0, 8'hd0, 1'b0, 2'b11);
		bitOp(0, 8'hd8, 1'b0, 2'b00);
		sfr(1'b0, 8'hd0, 8'h00, 9'h1dd);
		for (int b = 0; b < 4; b++) begin
			sfr(1'b1, 8'hd0, {3'b000, b[1:0], 3'b000}, 9'h000);
			regIndex = 3'(b + 4);
			@(negedge clk);
			check({8'h00, bankRamAddr}, {8'h00, 3'b000, b[1:0], 3'(b + 4)});
		end
		// Bit writes to the carry and to one half of the bank field.
		bitOp(1'b1, 8'hd7, 1'b1, 2'b00);
		bitOp(1'b1, 8'hd3, 1'b0, 2'b00);
		bitOp(1'b0, 8'hd7, 1'b0, 2'b11);
		sfr(1'b0, 8'hd0, 8'h00, 9'h191);
		core.setAcc(8'h00);
		sfr(1'b1, 8'hd0, 8'h3a, 9'h000);
		for (int i = 0; i < 10; i++) begin
			core.exec(psw_pkg::arith_op_t'(tbl[i][21:19]), tbl[i][18:11], tbl[i][10:3], i % 3);
			check({8'h00, pswValue}, {8'h00, tbl[i][2:1], 3'b111, tbl[i][0], 2'b10});
		end
		// An instruction and a byte write in one cycle: the instruction owns the arithmetic flags.
		fork
			core.exec(psw_pkg::ARITH_ADD, 8'hff, 8'h01, 0);
			sfr(1'b1, 8'hd0, 8'h00, 9'h000);
		join
		check({8'h00, pswValue}, 16'h00c0);
		// A write while the clock enable is low must leave the word alone.
		ce = 1'b0;
		sfr(1'b1, 8'hd0, 8'hff, 9'h000);
		ce = 1'b1;
		check({8'h00, pswValue}, 16'h00c0);
		// A second reset in mid-run clears every field and the operand address.
		arst_n = 1'b0;
		@(negedge clk);
		check({pswValue, bankRamAddr}, 16'h0000);
		arst_n = 1'b1;
		sfr(1'b0, 8'hd0, 8'h00, 9'h100);
		giveVerdict();
	end

	// Cuts a hung run short.
	initial begin
		repeat (3000) @(posedge clk);
		badCount++;
		giveVerdict();
	end
endmodule // program_status_flags_bench

bind program_status_flags program_status_flags_sva chk (.clk, .arst_n, .ce, .sfrAddr, .sfrWrEn, .sfrWrData,
	.sfrRdEn, .sfrRdData, .sfrRdHit, .bitWrEn, .aluUpdate, .aluOp, .aluOperandA, .aluOperandB, .accValue,
	.regIndex, .bankRamAddr, .pswValue);
`default_nettype wire
